// ===== ccu_pkg.sv
// constants for the capture/compare/pwm channel
// assumes one 8-bit register port and external first and period timers
package ccu_pkg;

    localparam int unsigned DATA_W = 8;
    localparam int unsigned ADDR_W = 3;
    localparam int unsigned T1_W = 16;
    localparam int unsigned PRE_W = 4;

    // register offsets
    localparam logic [2:0] OFS_CONTROL = 3'h0;
    localparam logic [2:0] OFS_CMP_LOW = 3'h1;
    localparam logic [2:0] OFS_CMP_HIGH = 3'h2;
    localparam logic [2:0] OFS_PERIOD = 3'h3;
    localparam logic [2:0] OFS_STATUS = 3'h4;

    // channel_control_reg fields
    localparam int unsigned MODE_LSB = 0;
    localparam int unsigned MODE_MSB = 3;
    localparam int unsigned DUTY_LO_LSB = 4;
    localparam int unsigned DUTY_LO_MSB = 5;

    // status fields; the event flag clears on a written one
    localparam int unsigned ST_FLAG = 0;
    localparam int unsigned ST_PIN = 1;

    // channel_mode_field codes
    localparam logic [3:0] MODE_OFF = 4'h0;
    localparam logic [3:0] MODE_CMP_TOGGLE = 4'h2;
    localparam logic [3:0] MODE_CAP_FALL = 4'h4;
    localparam logic [3:0] MODE_CAP_RISE = 4'h5;
    localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
    localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
    localparam logic [3:0] MODE_CMP_SET = 4'h8;
    localparam logic [3:0] MODE_CMP_CLEAR = 4'h9;
    localparam logic [3:0] MODE_CMP_FLAG = 4'hA;
    localparam logic [3:0] MODE_CMP_SPECIAL = 4'hB;
    localparam logic [1:0] MODE_PWM_TOP = 2'h3;

    // period timer prescale select codes
    localparam logic [1:0] PRESCALE_1 = 2'h0;
    localparam logic [1:0] PRESCALE_4 = 2'h1;

    // capture prescaler terminal counts
    localparam logic [3:0] PRE_LAST4 = 4'h3;
    localparam logic [3:0] PRE_LAST16 = 4'hF;

    // reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [3:0] RST_PRE = 4'h0;
    localparam logic [1:0] RST_PAIR = 2'h0;
    localparam logic [7:0] RST_PERIOD = 8'hFF;

endpackage : ccu_pkg

// ===== ccu_capture_compare_pwm.sv
// one capture/compare/pwm channel with its register port
// assumes the first timer and the period timer live outside and are
// synchronous to i_mclk; the channel pin input is synchronised here
`timescale 1ns/1ns
`default_nettype none

// Function
// RULE_01 - prescaler cleared when off or not capture
// RULE_02 - any reset clears the prescaler
// RULE_03 - capture prescale change keeps prescaler count
// RULE_04 - software turns channel off before prescale change
// RULE_05 - compare value checked against first timer
// RULE_06 - compare match drives pin and sets flag
// RULE_07 - mode 1010 only flags, pin released
// RULE_08 - mode 1011 resets timer, starts conversion
// RULE_09 - trigger at match, timer cleared next tick
// RULE_10 - special reset never sets overflow flag
// RULE_11 - vanished match cancels the timer reset
// RULE_12 - writing zero forces compare latch low
// RULE_13 - period end clears timer, sets pin, latches
// RULE_14 - period is (limit+1) times 4 times prescale
// RULE_15 - postscaler plays no part in period
// RULE_16 - ten bit duty, writable any time
// RULE_17 - duty double buffered at period end
// RULE_18 - high compare byte read only in pwm
// RULE_19 - time base adds two low bits
// RULE_20 - pin cleared when time base meets duty
// RULE_21 - duty beyond period leaves pin unchanged
// RULE_22 - resolution log2 of 4(limit+1) bits
// RULE_23 - period prescale ratios 1, 4, 16
// RULE_24 - capture copies timer count, sets flag
// RULE_25 - capture on fall, rise, fourth rise
// RULE_26 - timers arrive as inputs, not built here
module ccu_capture_compare_pwm
(
    input wire logic i_mclk,
    input wire logic i_reset_n,
    input wire logic [ccu_pkg::ADDR_W-1:0] i_addr,
    input wire logic [ccu_pkg::DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [ccu_pkg::DATA_W-1:0] o_rdata,
    input wire logic i_pin,
    output logic o_pin,
    output logic o_pin_oe_n,
    input wire logic [ccu_pkg::T1_W-1:0] i_first_timer_count, // RULE_26
    input wire logic i_first_timer_tick,
    output logic o_first_timer_clear,
    output logic o_special_trigger,
    input wire logic i_adc_enable,
    output logic o_adc_start,
    input wire logic [7:0] i_period_timer_count,
    input wire logic i_period_timer_tick,
    input wire logic [1:0] i_period_prescale,
    input wire logic [1:0] i_osc_phase,
    input wire logic [ccu_pkg::PRE_W-1:0] i_period_pre_count,
    output logic o_period_timer_clear,
    output logic o_event_flag
);
    import ccu_pkg::*;

    logic [3:0] mode_q;
    logic [1:0] duty_lo_q;
    logic [7:0] cmp_low_q;
    logic [7:0] cmp_high_q;
    logic [7:0] period_limit_q;
    logic [1:0] duty_latch_q;
    logic [3:0] pre_q;
    logic pin_s1_q;
    logic pin_s2_q;
    logic pin_s3_q;
    logic match_q;
    logic flag_q;
    logic pin_q;
    logic oe_n_q;
    logic t1_clear_q;
    logic trig_q;
    logic adc_q;
    logic t2_clear_q;
    logic [7:0] rdata_q;

    // decode
    wire logic wr_ctrl = i_wr && (i_addr == OFS_CONTROL);
    wire logic wr_low = i_wr && (i_addr == OFS_CMP_LOW);
    wire logic wr_high = i_wr && (i_addr == OFS_CMP_HIGH);
    wire logic wr_period = i_wr && (i_addr == OFS_PERIOD);
    wire logic wr_status = i_wr && (i_addr == OFS_STATUS);
    wire logic [3:0] new_mode = i_wdata[MODE_MSB:MODE_LSB];
    wire logic ctrl_zero = wr_ctrl && (i_wdata == RST_BYTE);

    wire logic is_pwm = (mode_q[3:2] == MODE_PWM_TOP);
    wire logic is_cap = (mode_q[3:2] == 2'h1);
    wire logic is_cmp = (mode_q == MODE_CMP_TOGGLE) ||
                        (mode_q[3:2] == 2'h2);
    wire logic cmp_drives = (mode_q == MODE_CMP_TOGGLE) ||
                            (mode_q == MODE_CMP_SET) ||
                            (mode_q == MODE_CMP_CLEAR);
    wire logic is_special = (mode_q == MODE_CMP_SPECIAL);

    // capture path
    wire logic pin_rise = pin_s2_q && !pin_s3_q;
    wire logic pin_fall = !pin_s2_q && pin_s3_q;
    wire logic pre_counts = (mode_q == MODE_CAP_RISE4) ||
                            (mode_q == MODE_CAP_RISE16);
    wire logic cap_evt =
        ((mode_q == MODE_CAP_FALL) && pin_fall) ||
        ((mode_q == MODE_CAP_RISE) && pin_rise) ||
        ((mode_q == MODE_CAP_RISE4) && pin_rise &&
         (pre_q[1:0] == PRE_LAST4[1:0])) ||
        ((mode_q == MODE_CAP_RISE16) && pin_rise &&
         (pre_q == PRE_LAST16)); // RULE_25
    // only a capture mode keeps its count; a move between two capture
    // modes keeps it too, so a stray capture can follow
    wire logic [3:0] pre_d = !is_cap ? RST_PRE :
        (pre_counts && pin_rise) ? pre_q + 4'h1 : pre_q; // RULE_01 RULE_03

    // compare path
    wire logic [15:0] cmp_value = {cmp_high_q, cmp_low_q};
    wire logic match_w = (i_first_timer_count == cmp_value); // RULE_05
    wire logic cmp_evt = is_cmp && match_w && !match_q;

    // pwm path: ten bit time base from the period timer and two low bits
    wire logic [1:0] base_lo = (i_period_prescale == PRESCALE_1) ?
        i_osc_phase : (i_period_prescale == PRESCALE_4) ?
        i_period_pre_count[1:0] : i_period_pre_count[3:2]; // RULE_19 RULE_23
    wire logic [9:0] time_base = {i_period_timer_count, base_lo}; // RULE_22
    wire logic [9:0] duty_buf = {cmp_high_q, duty_latch_q};
    wire logic [9:0] duty_new = {cmp_low_q, duty_lo_q}; // RULE_16
    // the period end is the increment after the count equals the limit;
    // the outside prescaler alone sets the tick rate, no postscaler
    wire logic period_end = is_pwm && i_period_timer_tick &&
        (i_period_timer_count == period_limit_q); // RULE_13 RULE_14 RULE_15
    // a duty above the period never meets the time base, so the pin
    // simply stays high
    // at 1:1 the time base steps every clock, so matching one step early
    // lines the registered clear up with the match; the prescaled ratios
    // step slower and there the clear lands one clock after the match
    wire logic [9:0] base_next = (i_period_prescale == PRESCALE_1) ?
        time_base + 10'h001 : time_base;
    wire logic duty_hit = is_pwm && (base_next == duty_buf); // RULE_20 RULE_21

    // pin latch next value
    logic pin_d;
    always_comb
    begin
        pin_d = pin_q;
        if (ctrl_zero)
            pin_d = 1'b0; // RULE_12
        else if (period_end)
            pin_d = (duty_new != 10'h000); // RULE_13
        else if (duty_hit)
            pin_d = 1'b0; // RULE_20
        else if (cmp_evt && (mode_q == MODE_CMP_TOGGLE))
            pin_d = !pin_q; // RULE_06
        else if (cmp_evt && (mode_q == MODE_CMP_SET))
            pin_d = 1'b1; // RULE_06
        else if (cmp_evt && (mode_q == MODE_CMP_CLEAR))
            pin_d = 1'b0; // RULE_06
    end

    // high compare byte: captures, pwm duty latch, or software
    logic [7:0] high_d;
    logic [7:0] low_d;
    always_comb
    begin
        high_d = cmp_high_q;
        low_d = cmp_low_q;
        if (cap_evt)
        begin
            high_d = i_first_timer_count[15:8]; // RULE_24
            low_d = i_first_timer_count[7:0]; // RULE_24
        end
        else
        begin
            if (period_end)
                high_d = cmp_low_q; // RULE_17
            else if (wr_high && !is_pwm)
                high_d = i_wdata; // RULE_18
            if (wr_low)
                low_d = i_wdata; // RULE_16
        end
    end

    // event flag: hardware set wins over a software clear
    wire logic flag_set = cap_evt || cmp_evt; // RULE_06 RULE_24
    wire logic flag_d = flag_set ||
        (flag_q && !(wr_status && i_wdata[ST_FLAG]));

    wire logic [7:0] rd_mux =
        (i_addr == OFS_CONTROL) ? {2'h0, duty_lo_q, mode_q} :
        (i_addr == OFS_CMP_LOW) ? cmp_low_q :
        (i_addr == OFS_CMP_HIGH) ? cmp_high_q :
        (i_addr == OFS_PERIOD) ? period_limit_q :
        (i_addr == OFS_STATUS) ? {6'h00, pin_q, flag_q} : RST_BYTE;

    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            mode_q <= MODE_OFF;
            duty_lo_q <= RST_PAIR;
            period_limit_q <= RST_PERIOD;
        end
        else
        begin
            if (wr_ctrl)
            begin
                mode_q <= new_mode;
                duty_lo_q <= i_wdata[DUTY_LO_MSB:DUTY_LO_LSB]; // RULE_16
            end
            if (wr_period)
                period_limit_q <= i_wdata;
        end
    end

    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            cmp_low_q <= RST_BYTE;
            cmp_high_q <= RST_BYTE;
            duty_latch_q <= RST_PAIR;
            pre_q <= RST_PRE; // RULE_02
        end
        else
        begin
            cmp_low_q <= low_d;
            cmp_high_q <= high_d;
            if (period_end)
                duty_latch_q <= duty_lo_q; // RULE_17
            pre_q <= pre_d;
        end
    end

    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            pin_s1_q <= 1'b0;
            pin_s2_q <= 1'b0;
            pin_s3_q <= 1'b0;
            match_q <= 1'b0;
            flag_q <= 1'b0;
        end
        else
        begin
            pin_s1_q <= i_pin;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            match_q <= match_w;
            flag_q <= flag_d;
        end
    end

    // the timer clear is a level the outside timer samples on its own
    // tick; it follows the live match so a rewritten value cancels it
    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            pin_q <= 1'b0;
            oe_n_q <= 1'b1;
            t1_clear_q <= 1'b0;
            trig_q <= 1'b0;
            adc_q <= 1'b0;
            t2_clear_q <= 1'b0;
            rdata_q <= RST_BYTE;
        end
        else
        begin
            pin_q <= pin_d;
            oe_n_q <= !(cmp_drives || is_pwm); // RULE_07 RULE_08
            t1_clear_q <= is_special && match_w; // RULE_09 RULE_11
            trig_q <= cmp_evt && is_special; // RULE_08 RULE_09
            adc_q <= cmp_evt && is_special && i_adc_enable; // RULE_08
            t2_clear_q <= period_end; // RULE_13
            rdata_q <= i_rd ? rd_mux : RST_BYTE;
        end
    end

    assign o_rdata = rdata_q;
    assign o_pin = pin_q;
    assign o_pin_oe_n = oe_n_q;
    // separate from any overflow flag: the timer must not flag this clear
    assign o_first_timer_clear = t1_clear_q; // RULE_10
    assign o_special_trigger = trig_q;
    assign o_adc_start = adc_q;
    assign o_period_timer_clear = t2_clear_q;
    assign o_event_flag = flag_q;

    sequence seq_special_match;
        is_special && cmp_evt ##1 match_w;
    endsequence

    sequence seq_pwm_wrap;
        period_end && !ctrl_zero ##1 1'b1;
    endsequence

    AST_PRE_CLEAR: assert property ( // RULE_01
        @(posedge i_mclk) disable iff (!i_reset_n)
        !is_cap |=> (pre_q == RST_PRE))
        else $error("prescaler not cleared outside capture");

    AST_PRE_KEEP: assert property ( // RULE_03
        @(posedge i_mclk) disable iff (!i_reset_n)
        is_cap && !pin_rise ##1 is_cap |-> $stable(pre_q))
        else $error("prescaler changed without an edge");

    AST_CAPTURE: assert property ( // RULE_24
        @(posedge i_mclk) disable iff (!i_reset_n)
        cap_evt |=> flag_q &&
            (cmp_value == $past(i_first_timer_count)))
        else $error("capture did not store timer count");

    AST_CMP_FLAG: assert property ( // RULE_06
        @(posedge i_mclk) disable iff (!i_reset_n)
        is_cmp && match_w && !match_q |=> flag_q)
        else $error("compare match left flag clear");

    AST_FLAG_ONLY: assert property ( // RULE_07
        @(posedge i_mclk) disable iff (!i_reset_n)
        (mode_q == MODE_CMP_FLAG) [*2] |-> o_pin_oe_n && $stable(pin_q))
        else $error("flag only mode touched the pin");

    AST_SPECIAL: assert property ( // RULE_08
        @(posedge i_mclk) disable iff (!i_reset_n)
        seq_special_match |-> o_special_trigger && o_first_timer_clear &&
            (o_adc_start == $past(i_adc_enable)))
        else $error("special event outputs wrong");

    AST_CANCEL: assert property ( // RULE_11
        @(posedge i_mclk) disable iff (!i_reset_n)
        !match_w |=> !o_first_timer_clear)
        else $error("timer clear without a match");

    AST_OFF_LOW: assert property ( // RULE_12
        @(posedge i_mclk) disable iff (!i_reset_n)
        i_wr && (i_addr == OFS_CONTROL) && (i_wdata == RST_BYTE)
            |=> !o_pin ##1 o_pin_oe_n)
        else $error("off write left latch high");

    AST_PWM_WRAP: assert property ( // RULE_13
        @(posedge i_mclk) disable iff (!i_reset_n)
        seq_pwm_wrap |-> o_period_timer_clear &&
            (cmp_high_q == $past(cmp_low_q)) &&
            (o_pin == ($past(duty_new) != 10'h000)))
        else $error("period end actions missing");

    AST_PWM_LOW: assert property ( // RULE_20
        @(posedge i_mclk) disable iff (!i_reset_n)
        duty_hit && !period_end && !ctrl_zero |=> !o_pin)
        else $error("pin not cleared at duty match");

    AST_HIGH_RO: assert property ( // RULE_18
        @(posedge i_mclk) disable iff (!i_reset_n)
        is_pwm && !period_end |=> $stable(cmp_high_q))
        else $error("high byte changed in pwm");

endmodule : ccu_capture_compare_pwm
`default_nettype wire

// ===== ccu_pin_model.sv
// far-side model: the signal source or load on the channel pin
// assumes the channel's pin output enable is active low
`timescale 1ns/1ns
`default_nettype none
module ccu_pin_model
(
    input wire logic i_level,
    input wire logic i_pin_drive,
    input wire logic i_pin_oe_n,
    output logic o_wire
);
    // the source only wins while the channel has let go of the pin
    assign o_wire = i_pin_oe_n ? i_level : i_pin_drive;
endmodule : ccu_pin_model
`default_nettype wire

// ===== tb_ccu_capture_compare_pwm.sv
// self-checking bench for the capture/compare/pwm channel
// assumes the pin model beside it; the period timer is modelled here, the first timer count is set directly
`timescale 1ns/1ns
`default_nettype none
module tb_ccu_capture_compare_pwm;
    import ccu_pkg::*;
    localparam logic [7:0] LIM = 8'h03;
    logic i_mclk, i_reset_n, i_wr, i_rd, ext, i_adc_enable, ptick, pin_w;
    logic o_pin, o_pin_oe_n, o_ftc, o_trig, o_adc, o_ptc, o_flag;
    logic [2:0] i_addr;
    logic [7:0] i_wdata, o_rdata, pcnt, rd;
    logic [15:0] t1;
    logic [1:0] phase;
    logic [1:0] psel;
    logic [3:0] pre;
    int fail_count, tests_run, trig_n, adc_n, clr_n;

    ccu_capture_compare_pwm uut (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .i_pin(pin_w), .o_pin(o_pin),
        .o_pin_oe_n(o_pin_oe_n), .i_first_timer_count(t1),
        .i_first_timer_tick(1'b1), .o_first_timer_clear(o_ftc),
        .o_special_trigger(o_trig), .i_adc_enable(i_adc_enable),
        .o_adc_start(o_adc), .i_period_timer_count(pcnt),
        .i_period_timer_tick(ptick), .i_period_prescale(psel),
        .i_osc_phase(phase), .i_period_pre_count(pre),
        .o_period_timer_clear(o_ptc), .o_event_flag(o_flag));
    ccu_pin_model pin_src (.i_level(ext), .i_pin_drive(o_pin),
        .i_pin_oe_n(o_pin_oe_n), .o_wire(pin_w));

    // the prescaler counts whole instruction cycles of four clocks
    assign ptick = (phase == 2'h3) && ((psel == PRESCALE_1) ||
        ((psel == PRESCALE_4) ? (pre[1:0] == 2'h3) : (pre == 4'hF)));
    initial
    begin
        i_mclk = 1'b0;
        forever #2 i_mclk = ~i_mclk;
    end
    // period timer wraps by itself at the limit, as a real one would
    always @(posedge i_mclk)
    begin
        phase <= phase + 2'h1;
        if (phase == 2'h3)
            pre <= pre + 4'h1;
        if (ptick)
            pcnt <= (pcnt == LIM) ? 8'h00 : pcnt + 8'h01;
        trig_n <= trig_n + int'(o_trig);
        adc_n <= adc_n + int'(o_adc);
        clr_n <= clr_n + int'(o_ptc);
    end

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : complete_run
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            fail_count++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge i_mclk);
    endtask : cyc
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask : wr
    task automatic rdc(input logic [2:0] a, input logic [7:0] exp);
        @(posedge i_mclk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1 chk(o_rdata, exp);
    endtask : rdc
    task automatic rises(input int n);
        repeat (n)
        begin
            ext <= 1'b1;
            cyc(5);
            ext <= 1'b0;
            cyc(5);
        end
    endtask : rises

    task automatic t_reset();
        rdc(OFS_CONTROL, 8'h00);
        rdc(OFS_PERIOD, 8'hFF);
        rdc(OFS_STATUS, 8'h00);
        rdc(3'h5, 8'h00);
    endtask : t_reset
    task automatic t_capture();
        t1 <= 16'h1234;
        wr(OFS_CONTROL, {4'h0, MODE_CAP_RISE});
        wr(OFS_STATUS, 8'h01);
        rises(1);
        rdc(OFS_CMP_LOW, 8'h34);
        rdc(OFS_CMP_HIGH, 8'h12);
        rdc(OFS_STATUS, 8'h01);
        wr(OFS_CONTROL, {4'h0, MODE_CAP_FALL});
        wr(OFS_STATUS, 8'h01);
        t1 <= 16'h0ABC;
        ext <= 1'b1;
        cyc(5);
        rdc(OFS_STATUS, 8'h00);
        ext <= 1'b0;
        cyc(5);
        rdc(OFS_CMP_LOW, 8'hBC);
        rdc(OFS_STATUS, 8'h01);
    endtask : t_capture
    task automatic t_prescale();
        wr(OFS_CONTROL, 8'h00);
        wr(OFS_CONTROL, {4'h0, MODE_CAP_RISE4});
        rises(3);
        wr(OFS_CONTROL, 8'h00);
        wr(OFS_CONTROL, {4'h0, MODE_CAP_RISE4});
        wr(OFS_STATUS, 8'h01);
        rises(3);
        rdc(OFS_STATUS, 8'h00);
        rises(1);
        rdc(OFS_STATUS, 8'h01);
        wr(OFS_STATUS, 8'h01);
        rises(2);
        wr(OFS_CONTROL, {4'h0, MODE_CAP_RISE16});
        wr(OFS_CONTROL, {4'h0, MODE_CAP_RISE4});
        rises(2);
        rdc(OFS_STATUS, 8'h01);
        rises(2);
        i_reset_n <= 1'b0;
        cyc(2);
        i_reset_n <= 1'b1;
        wr(OFS_CONTROL, {4'h0, MODE_CAP_RISE4});
        rises(2);
        rdc(OFS_STATUS, 8'h00);
    endtask : t_prescale
    task automatic match(input logic [3:0] m, input logic p, input logic oe);
        wr(OFS_CONTROL, {4'h0, m});
        wr(OFS_STATUS, 8'h01);
        t1 <= 16'h0010;
        cyc(3);
        chk(o_pin, p);
        chk(o_pin_oe_n, oe);
        chk(o_flag, 1'b1);
        chk(o_ftc, m == MODE_CMP_SPECIAL);
    endtask : match
    task automatic t_compare();
        int tr;
        int ad;
        t1 <= 16'h0000;
        wr(OFS_CMP_LOW, 8'h10);
        wr(OFS_CMP_HIGH, 8'h00);
        match(MODE_CMP_SET, 1'b1, 1'b0);
        t1 <= 16'h0000;
        match(MODE_CMP_CLEAR, 1'b0, 1'b0);
        t1 <= 16'h0000;
        match(MODE_CMP_TOGGLE, 1'b1, 1'b0);
        t1 <= 16'h0000;
        match(MODE_CMP_FLAG, 1'b1, 1'b1);
        t1 <= 16'h0000;
        tr = trig_n;
        ad = adc_n;
        match(MODE_CMP_SPECIAL, 1'b1, 1'b1);
        chk(8'(trig_n - tr), 8'h01);
        chk(8'(adc_n - ad), 8'h01);
        wr(OFS_CMP_LOW, 8'h11);
        cyc(2);
        chk(o_ftc, 1'b0);
        t1 <= 16'h0000;
        i_adc_enable <= 1'b0;
        wr(OFS_CMP_LOW, 8'h10);
        ad = adc_n;
        match(MODE_CMP_SPECIAL, 1'b1, 1'b1);
        chk(8'(adc_n - ad), 8'h00);
        wr(OFS_CONTROL, 8'h00);
        cyc(2);
        chk(o_pin, 1'b0);
        chk(o_pin_oe_n, 1'b1);
    endtask : t_compare
    task automatic pwm(input logic [7:0] lo, input logic [1:0] dl,
        input logic [7:0] exp, input logic [7:0] nclr);
        logic [7:0] hi;
        int c0;
        hi = 8'h00;
        wr(OFS_CMP_LOW, lo);
        wr(OFS_CONTROL, {2'b00, dl, 4'hC});
        cyc(40);
        c0 = clr_n;
        repeat (64)
        begin
            @(posedge i_mclk);
            #1 hi = hi + 8'(o_pin);
        end
        chk(hi, exp);
        chk(8'(clr_n - c0), nclr);
        chk(o_pin_oe_n, 1'b0);
    endtask : pwm
    task automatic t_pwm();
        wr(OFS_PERIOD, LIM);
        pwm(8'h01, 2'h2, 8'd24, 8'h04);
        wr(OFS_CMP_HIGH, 8'h55);
        rdc(OFS_CMP_HIGH, 8'h01);
        pwm(8'h00, 2'h0, 8'd0, 8'h04);
        pwm(8'hFF, 2'h0, 8'd64, 8'h04);
        rdc(OFS_CMP_HIGH, 8'hFF);
        psel <= PRESCALE_4;
        pwm(8'hFF, 2'h0, 8'd64, 8'h01);
    endtask : t_pwm

    initial
    begin
        i_reset_n = 1'b0;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_addr = 3'h0;
        i_wdata = 8'h00;
        ext = 1'b0;
        i_adc_enable = 1'b1;
        t1 = 16'h0000;
        pcnt = 8'h00;
        phase = 2'h0;
        psel = PRESCALE_1;
        pre = 4'h0;
        repeat (12) @(posedge i_mclk);
        i_reset_n <= 1'b1;
        t_reset();
        t_capture();
        t_prescale();
        t_compare();
        t_pwm();
        complete_run();
    end
    // far above the roughly 740 cycles the scenarios need
    initial
    begin
        #200000;
        fail_count++;
        complete_run();
    end
endmodule : tb_ccu_capture_compare_pwm
`default_nettype wire
